// ===== rtl/pulse_updown_counter.sv
// pulse up/down counter with prescaler, scaling and limit flashing
// assumes an APB master on mclk and raw pins from the field
`timescale 1ns/10ps

module pulse_updown_counter (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // field pins
  input wire logic pulseIn,
  input wire logic resetContact,
  input wire logic alarm1In,
  input wire logic alarm2In,
  // display
  output logic [15:0] displayValue,
  output logic [1:0] decimalPos,
  output logic flashDigits,
  // interrupt
  output logic irq
);

  typedef struct packed {
    logic [1:0] pinS0;       // two-stage synchroniser, first of 4 pins
    logic [1:0] pinS1;
    logic [1:0] pinS2;
    logic [1:0] pinS3;
    logic [13:0] ctrl;       // control fields
    logic [13:0] prescale;   // prescale_divisor
    logic [13:0] fullScale;  // display full-scale
    logic [13:0] pulseFull;  // pulse full-scale count
    logic [13:0] preload;    // reset preload value
    logic [15:0] upperLim;   // upper_display_limit
    logic [15:0] lowerLim;   // lower_display_limit
    logic [6:0] zeroBand;    // zero band width
    logic [13:0] preCnt;     // prescaler remainder
    logic [31:0] count;      // signed prescaled count
    logic [26:0] tick;       // system time divider
    logic [5:0] minute;      // seconds within the minute
    logic resetHeld;         // reset contact seen last cycle
    logic [15:0] disp;       // displayed value
    logic flash;
    logic [2:0] irqStat;
    logic [2:0] irqMask;
    logic [31:0] rdata;
  } top_s;

  top_s q, d;
  // reset release chain, kept outside the struct: it runs on the raw reset
  logic [1:0] rstSync_q;

  // synchronised pins, read only through the second stage
  logic pulseSync;
  logic resetSync;
  logic alarm1Sync;
  logic alarm2Sync;
  logic rstSyncN;

  assign rstSyncN = rstSync_q[1];
  assign pulseSync = q.pinS0[1];
  assign resetSync = q.pinS1[1];
  assign alarm1Sync = q.pinS2[1];
  assign alarm2Sync = q.pinS3[1];

  debounce_bus_if dbus ();

  // debounce minimum length lookup, in clock cycles
  function automatic logic [22:0] min_cycles(input logic [3:0] s);
    int unsigned us;
    case (s)
      4'h1: us = pulse_counter_pkg::Min2HzUs;
      4'h2: us = pulse_counter_pkg::Min5HzUs;
      4'h3: us = pulse_counter_pkg::Min10HzUs;
      4'h4: us = pulse_counter_pkg::Min20HzUs;
      4'h5: us = pulse_counter_pkg::Min50HzUs;
      4'h6: us = pulse_counter_pkg::Min100HzUs;
      4'h7: us = pulse_counter_pkg::Min200HzUs;
      default: us = pulse_counter_pkg::Min500HzUs;
    endcase
    min_cycles = 23'(us * pulse_counter_pkg::CyclesPerUs);
  endfunction : min_cycles

  // linear scaling with no offset term, rounded toward zero
  function automatic logic [31:0] scale(input logic [31:0] c,
      input logic [13:0] fs, input logic [13:0] pf);
    logic signed [47:0] prod;
    prod = 48'(signed'(c)) * signed'({34'h0, fs});
    if (pf == 14'h0) begin
      scale = '0;
    end else begin
      scale = 32'(prod / signed'({34'h0, pf}));
    end
  endfunction : scale

  // configured fields
  pulse_counter_pkg::counter_base_e base;
  pulse_counter_pkg::flash_assign_e flashSel;
  logic fallActive;
  logic downMode;

  assign base = pulse_counter_pkg::counter_base_e'(
      q.ctrl[pulse_counter_pkg::CtrlBaseLsb +: 2]);
  assign flashSel = pulse_counter_pkg::flash_assign_e'(
      q.ctrl[pulse_counter_pkg::CtrlFlashLsb +: 2]);
  assign fallActive = q.ctrl[pulse_counter_pkg::CtrlEdgeBit];
  assign downMode = q.ctrl[pulse_counter_pkg::CtrlDownBit];
  assign dbus.setting = q.ctrl[pulse_counter_pkg::CtrlFiltLsb +: 4];
  assign dbus.minCycles = min_cycles(dbus.setting);

  debounce_filter filter (
    .mclk(mclk),
    .rstSyncN(rstSyncN),
    .pinSync(pulseSync),
    .bus(dbus)
  );

  // apb decode: one wait-free access phase
  logic access;
  logic wr;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign pready = 1'b1;

  logic mapped;
  always_comb begin
    case (paddr)
      pulse_counter_pkg::CtrlOff, pulse_counter_pkg::PrescaleOff,
      pulse_counter_pkg::FullScaleOff, pulse_counter_pkg::PulseFullOff,
      pulse_counter_pkg::PreloadOff, pulse_counter_pkg::UpperLimOff,
      pulse_counter_pkg::LowerLimOff, pulse_counter_pkg::ZeroBandOff,
      pulse_counter_pkg::DisplayOff, pulse_counter_pkg::CountOff,
      pulse_counter_pkg::IrqStatusOff, pulse_counter_pkg::IrqMaskOff:
        mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = access & ~mapped;

  // next-state logic for the whole block
  always_comb begin
    logic event1;     // one accepted input event
    logic prescOut;   // one prescaled count
    logic gateOn;     // time gate open
    logic secTick;
    logic [31:0] startCnt;
    logic [31:0] shown;
    logic signed [31:0] sv;
    logic over;
    logic under;
    logic alarmFlash;
    event1 = 1'b0;
    prescOut = 1'b0;
    gateOn = 1'b0;
    secTick = 1'b0;
    startCnt = '0;
    shown = '0;
    sv = '0;
    over = 1'b0;
    under = 1'b0;
    alarmFlash = 1'b0;
    d = q;
    d.pinS0 = {q.pinS0[0], pulseIn};
    d.pinS1 = {q.pinS1[0], resetContact};
    d.pinS2 = {q.pinS2[0], alarm1In};
    d.pinS3 = {q.pinS3[0], alarm2In};

    // event source
    gateOn = fallActive ? ~dbus.level : dbus.level;
    case (base)
      pulse_counter_pkg::PulseCountBase: begin
        event1 = fallActive ? dbus.fall : dbus.rise;
        d.tick = '0;
      end
      pulse_counter_pkg::SecondsBase,
      pulse_counter_pkg::MinutesBase: begin
        // time stands while the gate is closed; the phase is kept
        if (gateOn) begin
          if (q.tick == 27'(pulse_counter_pkg::SecondCycles - 1)) begin
            d.tick = '0;
            secTick = 1'b1;
          end else begin
            d.tick = q.tick + 27'h1;
          end
        end
        if (base == pulse_counter_pkg::SecondsBase) begin
          event1 = secTick;
        end else if (secTick) begin
          if (q.minute ==
              6'(pulse_counter_pkg::SecondsPerMinute - 1)) begin
            d.minute = '0;
            event1 = 1'b1;
          end else begin
            d.minute = q.minute + 6'h1;
          end
        end
      end
      default: event1 = 1'b0;
    endcase

    // prescaler with remainder
    if (event1) begin
      if (q.preCnt + 14'h1 >= q.prescale) begin
        d.preCnt = '0;
        prescOut = 1'b1;
      end else begin
        d.preCnt = q.preCnt + 14'h1;
      end
    end

    // up counts from zero, down counts from pulse full-scale
    startCnt = downMode ? {18'h0, q.pulseFull} : '0;
    d.resetHeld = resetSync;
    if (resetSync) begin
      if (q.preload == 14'h0) begin
        d.count = startCnt;
        d.preCnt = '0;
      end else if (!q.resetHeld) begin
        // preload shifts once per assertion, against the direction
        d.count = downMode ? q.count + {18'h0, q.preload}
                           : q.count - {18'h0, q.preload};
      end
    end else if (prescOut) begin
      d.count = downMode ? q.count - 32'h1 : q.count + 32'h1;
    end

    // display value and zero band
    shown = scale(q.count, q.fullScale, q.pulseFull);
    sv = signed'(shown);
    if (sv <= signed'({25'h0, q.zeroBand}) &&
        sv >= -signed'({25'h0, q.zeroBand})) begin
      sv = '0;
    end
    // limits clamp the shown value and flash
    if (sv >= signed'({{16{q.upperLim[15]}}, q.upperLim})) begin
      over = 1'b1;
      sv = signed'({{16{q.upperLim[15]}}, q.upperLim});
    end else if (sv <= signed'({{16{q.lowerLim[15]}}, q.lowerLim})) begin
      under = 1'b1;
      sv = signed'({{16{q.lowerLim[15]}}, q.lowerLim});
    end
    d.disp = sv[15:0];

    // alarm flashing as chosen
    case (flashSel)
      pulse_counter_pkg::FlashOnFirstAlarm: alarmFlash = alarm1Sync;
      pulse_counter_pkg::FlashOnSecondAlarm: alarmFlash = alarm2Sync;
      pulse_counter_pkg::FlashOnBothAlarms:
        alarmFlash = alarm1Sync | alarm2Sync;
      default: alarmFlash = 1'b0;
    endcase
    d.flash = over | under | alarmFlash;

    // register writes
    if (wr) begin
      case (paddr)
        pulse_counter_pkg::CtrlOff: d.ctrl = pwdata[13:0];
        pulse_counter_pkg::PrescaleOff:
          d.prescale = (pwdata[13:0] == 14'h0) ? 14'h1 : pwdata[13:0];
        pulse_counter_pkg::FullScaleOff: d.fullScale = pwdata[13:0];
        pulse_counter_pkg::PulseFullOff: d.pulseFull = pwdata[13:0];
        pulse_counter_pkg::PreloadOff: d.preload = pwdata[13:0];
        pulse_counter_pkg::UpperLimOff: d.upperLim = pwdata[15:0];
        pulse_counter_pkg::LowerLimOff: d.lowerLim = pwdata[15:0];
        pulse_counter_pkg::ZeroBandOff:
          d.zeroBand = (pwdata[6:0] > pulse_counter_pkg::ZeroBandMax)
                       ? pulse_counter_pkg::ZeroBandMax : pwdata[6:0];
        pulse_counter_pkg::CountOff: d.count = pwdata;
        pulse_counter_pkg::IrqStatusOff:
          d.irqStat = q.irqStat & ~pwdata[2:0];
        pulse_counter_pkg::IrqMaskOff: d.irqMask = pwdata[2:0];
        default: d.ctrl = q.ctrl;
      endcase
    end
    // events set after the clear so a set in the same cycle wins
    if (prescOut) d.irqStat[pulse_counter_pkg::IrqCount] = 1'b1;
    if (over && !q.flash) d.irqStat[pulse_counter_pkg::IrqOver] = 1'b1;
    if (under && !q.flash) d.irqStat[pulse_counter_pkg::IrqUnder] = 1'b1;

    // read data latched in the setup phase, shown in the access phase
    case (paddr)
      pulse_counter_pkg::CtrlOff: d.rdata = {18'h0, q.ctrl};
      pulse_counter_pkg::PrescaleOff: d.rdata = {18'h0, q.prescale};
      pulse_counter_pkg::FullScaleOff: d.rdata = {18'h0, q.fullScale};
      pulse_counter_pkg::PulseFullOff: d.rdata = {18'h0, q.pulseFull};
      pulse_counter_pkg::PreloadOff: d.rdata = {18'h0, q.preload};
      pulse_counter_pkg::UpperLimOff: d.rdata = {16'h0, q.upperLim};
      pulse_counter_pkg::LowerLimOff: d.rdata = {16'h0, q.lowerLim};
      pulse_counter_pkg::ZeroBandOff: d.rdata = {25'h0, q.zeroBand};
      pulse_counter_pkg::DisplayOff: d.rdata = {16'h0, q.disp};
      pulse_counter_pkg::CountOff: d.rdata = q.count;
      pulse_counter_pkg::IrqStatusOff: d.rdata = {29'h0, q.irqStat};
      pulse_counter_pkg::IrqMaskOff: d.rdata = {29'h0, q.irqMask};
      default: d.rdata = '0;
    endcase
  end

  // reset release chain uses the raw reset; one process per variable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_q <= '0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end

  // everything else resets from the released copy
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      q.pinS0 <= '0;
      q.pinS1 <= '0;
      q.pinS2 <= '0;
      q.pinS3 <= '0;
      q.ctrl <= '0;
      q.prescale <= pulse_counter_pkg::PrescaleRst;
      q.fullScale <= pulse_counter_pkg::FullScaleRst;
      q.pulseFull <= pulse_counter_pkg::PulseFullRst;
      q.preload <= '0;
      q.upperLim <= {2'h0, pulse_counter_pkg::UpperLimRst};
      q.lowerLim <= pulse_counter_pkg::LowerLimRst;
      q.zeroBand <= '0;
      q.preCnt <= '0;
      q.count <= '0;
      q.tick <= '0;
      q.minute <= '0;
      q.resetHeld <= 1'b0;
      q.disp <= '0;
      q.flash <= 1'b0;
      q.irqStat <= '0;
      q.irqMask <= '0;
      q.rdata <= '0;
    end else begin
      q.pinS0 <= d.pinS0;
      q.pinS1 <= d.pinS1;
      q.pinS2 <= d.pinS2;
      q.pinS3 <= d.pinS3;
      q.ctrl <= d.ctrl;
      q.prescale <= d.prescale;
      q.fullScale <= d.fullScale;
      q.pulseFull <= d.pulseFull;
      q.preload <= d.preload;
      q.upperLim <= d.upperLim;
      q.lowerLim <= d.lowerLim;
      q.zeroBand <= d.zeroBand;
      q.preCnt <= d.preCnt;
      q.count <= d.count;
      q.tick <= d.tick;
      q.minute <= d.minute;
      q.resetHeld <= d.resetHeld;
      q.disp <= d.disp;
      q.flash <= d.flash;
      q.irqStat <= d.irqStat;
      q.irqMask <= d.irqMask;
      q.rdata <= d.rdata;
    end
  end

  // outputs
  assign prdata = q.rdata;
  assign displayValue = q.disp;
  assign decimalPos = q.ctrl[pulse_counter_pkg::CtrlDotLsb +: 2];
  assign flashDigits = q.flash;
  assign irq = |(q.irqStat & q.irqMask);

endmodule : pulse_updown_counter

// ===== rtl/pulse_counter_pkg.sv
// package for the pulse up/down counter: register map, fields, timing
// assumes a 10 MHz system clock and an APB register port with 32-bit data
package pulse_counter_pkg;

  // system clock
  localparam int unsigned ClkHz = 10_000_000;

  // debounce minimum pulse lengths in microseconds (2.5 ms is 2500 us)
  localparam int unsigned Min2HzUs = 250_000;
  localparam int unsigned Min5HzUs = 100_000;
  localparam int unsigned Min10HzUs = 50_000;
  localparam int unsigned Min20HzUs = 25_000;
  localparam int unsigned Min50HzUs = 10_000;
  localparam int unsigned Min100HzUs = 5_000;
  localparam int unsigned Min200HzUs = 2_500;
  localparam int unsigned Min500HzUs = 1_000;
  localparam int unsigned CyclesPerUs = ClkHz / 1_000_000;

  // one second of system time
  localparam int unsigned SecondUs = 1_000_000;
  localparam int unsigned SecondCycles = SecondUs * CyclesPerUs;
  localparam int unsigned SecondsPerMinute = 60;

  // register byte offsets (chosen)
  localparam logic [7:0] CtrlOff = 8'h00;
  localparam logic [7:0] PrescaleOff = 8'h04;
  localparam logic [7:0] FullScaleOff = 8'h08;
  localparam logic [7:0] PulseFullOff = 8'h0c;
  localparam logic [7:0] PreloadOff = 8'h10;
  localparam logic [7:0] UpperLimOff = 8'h14;
  localparam logic [7:0] LowerLimOff = 8'h18;
  localparam logic [7:0] ZeroBandOff = 8'h1c;
  localparam logic [7:0] DisplayOff = 8'h20;
  localparam logic [7:0] CountOff = 8'h24;
  localparam logic [7:0] IrqStatusOff = 8'h28;
  localparam logic [7:0] IrqMaskOff = 8'h2c;

  // control register field positions
  localparam int unsigned CtrlBaseLsb = 0;   // 2 bits: counter_base_select
  localparam int unsigned CtrlEdgeBit = 2;   // 1 = falling_active_polarity
  localparam int unsigned CtrlDownBit = 3;   // 1 = down counting
  localparam int unsigned CtrlFiltLsb = 4;   // 4 bits: debounce_setting
  localparam int unsigned CtrlDotLsb = 8;    // 2 bits: decimal point
  localparam int unsigned CtrlFlashLsb = 10; // 2 bits: flash_assign
  localparam int unsigned CtrlAlarmLsb = 12; // 2 bits: alarm inputs in use

  // reset values
  localparam logic [13:0] PrescaleRst = 14'h0001;
  localparam logic [13:0] FullScaleRst = 14'h03e8;  // 1000
  localparam logic [13:0] PulseFullRst = 14'h03e8;
  localparam logic [13:0] UpperLimRst = 14'h270f;  // 9999
  localparam logic [15:0] LowerLimRst = 16'hf831;  // -1999
  localparam logic [6:0] ZeroBandMax = 7'h63;      // 99

  // interrupt status bits
  localparam int unsigned IrqCount = 0;
  localparam int unsigned IrqOver = 1;
  localparam int unsigned IrqUnder = 2;
  localparam int unsigned IrqWidth = 3;

  // counter base
  typedef enum logic [1:0] {
    PulseCountBase,
    SecondsBase,
    MinutesBase
  } counter_base_e;

  // flash assignment
  typedef enum logic [1:0] {
    FlashNone,
    FlashOnFirstAlarm,
    FlashOnSecondAlarm,
    FlashOnBothAlarms
  } flash_assign_e;

  // debounce setting codes: 0 = off, 1..8 = 2..500 Hz
  localparam logic [3:0] DebounceOff = 4'h0;

endpackage : pulse_counter_pkg

// ===== rtl/debounce_bus_if.sv
// carries the debounce filter's settings and results
// assumes one clock domain shared by both ends
`timescale 1ns/10ps
interface debounce_bus_if;
  logic [3:0] setting;  // debounce_setting code
  logic [22:0] minCycles; // stable cycles needed
  logic level;          // filtered level
  logic rise;           // one-cycle pulse on filtered rising edge
  logic fall;           // one-cycle pulse on filtered falling edge
  modport filter (input setting, input minCycles, output level,
                  output rise, output fall);
  modport user (output setting, output minCycles, input level,
                input rise, input fall);
endinterface : debounce_bus_if

// ===== rtl/debounce_filter.sv
// debounce filter for the synchronised pulse input
// assumes its input is already synchronised to mclk
`timescale 1ns/10ps
module debounce_filter (
  // clock and reset
  input wire logic mclk,
  input wire logic rstSyncN,
  // synchronised input
  input wire logic pinSync,
  // settings and results
  debounce_bus_if.filter bus
);

  typedef struct packed {
    logic level;      // accepted level
    logic [22:0] cnt; // cycles the raw level has differed
    logic rise;
    logic fall;
  } debounce_setting_s;

  debounce_setting_s q, d;

  // with filtering on, a change is accepted only after it stood for the whole minimum length
  always_comb begin
    d = q;
    d.rise = 1'b0;
    d.fall = 1'b0;
    if (bus.setting == pulse_counter_pkg::DebounceOff) begin
      // off: accept any length, no timing at all
      d.cnt = '0;
      if (pinSync != q.level) begin
        d.level = pinSync;
        d.rise = pinSync;
        d.fall = ~pinSync;
      end
    end else if (pinSync == q.level) begin
      // a short glitch is dropped and the count restarts
      d.cnt = '0;
    end else if (q.cnt + 23'h1 >= bus.minCycles) begin
      d.cnt = '0;
      d.level = pinSync;
      d.rise = pinSync;
      d.fall = ~pinSync;
    end else begin
      d.cnt = q.cnt + 23'h1;
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.level = q.level;
  assign bus.rise = q.rise;
  assign bus.fall = q.fall;

endmodule : debounce_filter

// ===== verif/pulse_updown_counter_monitor.sv
// checker on the counter's bus, display and interrupt pins
// assumes it is bound to pulse_updown_counter, one mclk domain
`timescale 1ns/10ps
module pulse_updown_counter_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // field pin and display
  input wire logic resetContact,
  input wire logic [15:0] displayValue,
  input wire logic [1:0] decimalPos,
  input wire logic irq
);
  // access phase, and an address off the word-aligned map
  logic acc;
  logic hole;
  assign acc = psel && penable;
  assign hole = paddr > 8'h2c || paddr[1:0] != 2'b00;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  no_wait_a: assert property (acc |-> pready)
    else $error("wait state inserted");
  hole_err_a: assert property (acc && hole |-> pslverr)
    else $error("unmapped access not refused");
  map_ok_a: assert property (acc && !hole |-> !pslverr)
    else $error("mapped access refused");
  hole_zero_a: assert property (acc && !pwrite && hole |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  dot_follow_a: assert property (
    acc && pwrite && paddr == pulse_counter_pkg::CtrlOff
    |=> decimalPos == $past(pwdata[9:8]))
    else $error("decimal point not taken from control");
  mask_quiet_a: assert property (
    acc && pwrite && paddr == pulse_counter_pkg::IrqMaskOff &&
    pwdata[2:0] == 3'h0 |=> !irq)
    else $error("interrupt with all sources masked");
  display_read_a: assert property (
    acc && !pwrite && paddr == pulse_counter_pkg::DisplayOff
    |-> prdata[15:0] == displayValue ||
        prdata[15:0] == $past(displayValue))
    else $error("display register differs from display pins");
  zero_count_a: assert property (
    acc && pwrite && paddr == pulse_counter_pkg::CountOff &&
    pwdata == 32'h0 && !resetContact |-> ##[1:3] displayValue == 16'h0)
    else $error("zero count not shown as zero");
endmodule : pulse_updown_counter_monitor

bind pulse_updown_counter pulse_updown_counter_monitor
  pulse_updown_counter_monitor_inst (.mclk(mclk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .resetContact(resetContact), .displayValue(displayValue),
  .decimalPos(decimalPos), .irq(irq));

// ===== verif/pulse_source.sv
// contact model: sensor output or switch on the pulse pin
// assumes the bench's mclk; the line idles low as with a pulldown
`timescale 1ns/10ps
module pulse_source (
  // clock
  input wire logic mclk,
  // pin towards the counter
  output logic pulseOut
);
  initial pulseOut = 1'b0;
  // one pulse: high for hi cycles, then low for lo cycles
  task automatic pulse(input int hi, input int lo);
    @(posedge mclk);
    pulseOut <= 1'b1;
    repeat (hi) @(posedge mclk);
    pulseOut <= 1'b0;
    repeat (lo) @(posedge mclk);
  endtask : pulse
  // a steady level, used as gate or for single edges
  task automatic hold(input logic lvl);
    @(posedge mclk);
    pulseOut <= lvl;
  endtask : hold
endmodule : pulse_source

// ===== verif/test_pulse_updown_counter.sv
// self-checking bench for the pulse up/down counter
// assumes the bound checker and the contact model on the pin
`timescale 1ns/10ps
module test_pulse_updown_counter;
  // stimulus
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic resetContact = 1'b0;
  logic alarm1In = 1'b0;
  logic alarm2In = 1'b0;
  // design outputs and pin
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pulseIn;
  logic [15:0] displayValue;
  logic [1:0] decimalPos;
  logic flashDigits;
  logic irq;
  // bookkeeping
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [31:0] rdata;
  logic rerr;

  pulse_updown_counter pulse_updown_counter_inst (.mclk(mclk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pulseIn(pulseIn), .resetContact(resetContact),
    .alarm1In(alarm1In), .alarm2In(alarm2In),
    .displayValue(displayValue), .decimalPos(decimalPos),
    .flashDigits(flashDigits), .irq(irq));
  pulse_source pulse_source_inst (.mclk(mclk), .pulseOut(pulseIn));

  // 10 MHz clock
  initial begin
    forever #50 mclk = ~mclk;
  end

  // hang guard, above the longest run of about 45k cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 100000) begin
      num_errors++;
      final_report();
    end
  end

  // one apb transfer; data taken at the edge where pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  // read a register and compare it
  task automatic rdck(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdata, exp);
  endtask : rdck

  task automatic disp(input logic [15:0] exp);
    repeat (3) @(posedge mclk);
    check({16'h0, displayValue}, {16'h0, exp});
  endtask : disp

  // reset values, read-only and unmapped places
  task automatic t_regs;
    rdck(8'h04, 32'h1);
    rdck(8'h08, 32'd1000);
    rdck(8'h14, 32'd9999);
    apb(1'b1, 8'h20, 32'h1234);
    disp(16'h0);
    apb(1'b1, 8'h30, 32'h1);
    check({31'h0, rerr}, 32'h1);
    rdck(8'h30, 32'h0);
    $display("test regs done");
  endtask : t_regs

  // prescaled short pulses, scaling and the count interrupt
  task automatic t_count;
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h04, 32'd3);
    apb(1'b1, 8'h08, 32'd2000);
    apb(1'b1, 8'h24, 32'h0);
    apb(1'b1, 8'h28, 32'h7);
    apb(1'b1, 8'h2c, 32'h1);
    repeat (7) pulse_source_inst.pulse(1, 4);
    repeat (8) @(posedge mclk);
    rdck(8'h24, 32'd2);
    disp(16'd4);
    rdck(8'h20, 32'd4);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, 8'h28, 32'h1);
    @(posedge mclk);
    check({31'h0, irq}, 32'h0);
    repeat (2) pulse_source_inst.pulse(1, 4);
    repeat (8) @(posedge mclk);
    rdck(8'h24, 32'd3);
    apb(1'b1, 8'h2c, 32'h0);
    $display("test count done");
  endtask : t_count

  // falling edge select, then seconds base with pin as gate
  task automatic t_edge;
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b1, 8'h00, 32'h4);
    apb(1'b1, 8'h24, 32'h0);
    pulse_source_inst.hold(1'b1);
    repeat (10) @(posedge mclk);
    rdck(8'h24, 32'h0);
    pulse_source_inst.hold(1'b0);
    repeat (10) @(posedge mclk);
    rdck(8'h24, 32'h1);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h24, 32'h0);
    repeat (3) pulse_source_inst.pulse(20, 5);
    rdck(8'h24, 32'h0);
    $display("test edge done");
  endtask : t_edge

  // 1 ms filter: a short pulse is dropped, a long one counted
  task automatic t_filter;
    apb(1'b1, 8'h00, 32'h80);
    apb(1'b1, 8'h24, 32'h0);
    pulse_source_inst.pulse(9000, 12000);
    rdck(8'h24, 32'h0);
    pulse_source_inst.pulse(11000, 12000);
    rdck(8'h24, 32'h1);
    $display("test filter done");
  endtask : t_filter

  // down counting, held reset contact and the preload shift
  task automatic t_down;
    apb(1'b1, 8'h08, 32'd1000);
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h00, 32'h8);
    resetContact <= 1'b1;
    pulse_source_inst.pulse(1, 8);
    rdck(8'h24, 32'd1000);
    disp(16'd1000);
    resetContact <= 1'b0;
    repeat (6) @(posedge mclk);
    pulse_source_inst.pulse(1, 8);
    rdck(8'h24, 32'd999);
    apb(1'b1, 8'h10, 32'd5);
    resetContact <= 1'b1;
    repeat (8) @(posedge mclk);
    resetContact <= 1'b0;
    repeat (6) @(posedge mclk);
    rdck(8'h24, 32'd1004);
    disp(16'd1004);
    $display("test down done");
  endtask : t_down

  // limit clamp, zero band, flash assignment and decimal point
  task automatic t_display;
    logic [15:0] cv [4] = '{16'h0003, 16'hfffc, 16'h0006, 16'hfffa};
    logic [15:0] ev [4] = '{16'h0000, 16'h0000, 16'h0006, 16'hfffa};
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h14, 32'd10);
    apb(1'b1, 8'h24, 32'd12);
    disp(16'd10);
    check({31'h0, flashDigits}, 32'h1);
    apb(1'b1, 8'h14, 32'd9999);
    apb(1'b1, 8'h1c, 32'd5);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h24, {{16{cv[i][15]}}, cv[i]});
      disp(ev[i]);
    end
    // lower limit at -5 clamps the -6 count and flashes
    apb(1'b1, 8'h18, 32'hfffb);
    disp(16'hfffb);
    check({31'h0, flashDigits}, 32'h1);
    apb(1'b1, 8'h18, 32'hf831);
    for (int f = 0; f < 16; f++) begin
      apb(1'b1, 8'h00, {18'h0, 2'b11, f[3:2], 10'h0});
      alarm1In <= f[0];
      alarm2In <= f[1];
      repeat (5) @(posedge mclk);
      check({31'h0, flashDigits},
        {31'h0, (f[2] & f[0]) | (f[3] & f[1])});
    end
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, 8'h00, {22'h0, d[1:0], 8'h0});
      @(posedge mclk);
      check({30'h0, decimalPos}, {30'h0, d[1:0]});
    end
    $display("test display done");
  endtask : t_display

  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // main sequence
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_regs();
    t_count();
    t_edge();
    t_filter();
    t_down();
    t_display();
    final_report();
  end
endmodule : test_pulse_updown_counter
